//--- hw/sadc_regs.svh
/*
  Register offsets, field positions, reset values and step timing for the
  successive-approximation converter control block.
  Assumes byte addresses on a 12-bit APB address, one aligned word each.
*/
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

`define SADC_OFS_CONV_MODE    12'h000
`define SADC_OFS_CHAN_SEL     12'h004
`define SADC_OFS_RESULT_FULL  12'h008
`define SADC_OFS_RESULT_UPPER 12'h00C
`define SADC_OFS_RESULT_LOWER 12'h010
`define SADC_OFS_PIN_CFG0     12'h014
`define SADC_OFS_PIN_CFG1     12'h018
`define SADC_OFS_PORT2_DIR    12'h01C
`define SADC_OFS_PORT7_DIR    12'h020
`define SADC_OFS_CMP_CTL0     12'h024
`define SADC_OFS_CMP_CTL1     12'h028
`define SADC_OFS_CMP_CTL2     12'h02C
`define SADC_OFS_STATUS       12'h030

`define SADC_CHAN_MSB         3
`define SADC_CMP_ENABLE_BIT   7
`define SADC_CMP_MODE_HI_BIT  4
`define SADC_CMP_MODE_LO_BIT  3

`define SADC_RST_MODE         8'h00
`define SADC_RST_CHAN         8'h00
`define SADC_RST_PIN_CFG      8'h00
`define SADC_RST_PORT_DIR     8'hFF
`define SADC_RST_CMP_CTL      8'h00
`define SADC_RST_RESULT       16'h0000

`define SADC_SAR_MSB_IDX      4'h9
`define SADC_SAR_TRIAL_MSB    10'h200
`define SADC_SAMPLE_STEPS     4'h4
`define SADC_STEP_BASE        8'h02

`endif

//--- hw/sadc_pkg.sv
/*
  Types shared by the converter control block and its step divider.
  Assumes the register header supplies all numeric constants.
*/
package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_ST_IDLE    = 2'b00,
    SADC_ST_SAMPLE  = 2'b01,
    SADC_ST_COMPARE = 2'b10
  } sadc_state_t;

  typedef struct packed {
    logic       conversion_run;
    logic       rsv;
    logic [2:0] conv_time_sel;
    logic [1:0] op_level_sel;
    logic       comparator_power_on;
  } sadc_mode_t;

  typedef struct packed {
    logic       comparator_enable_flag;
    logic [1:0] rsv_hi;
    logic       comparator_mode_sel_hi;
    logic       comparator_mode_sel_lo;
    logic [2:0] rsv_lo;
  } sadc_cmp_ctl_t;

  typedef struct packed {
    logic [8:0] convert;
    logic [8:0] comparator;
    logic [8:0] digital;
  } sadc_pin_route_t;

endpackage : sadc_pkg

//--- hw/sadc_step_div.sv
/*
  Step-rate divider: one-cycle tick per conversion step interval.
  Assumes the caller restarts it on every sequencer state change.
*/
`timescale 1ns/1ns
`include "sadc_regs.svh"

module sadc_step_div (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       restart,
  input  wire logic [2:0] div_sel,
  output logic            tick
);
  import sadc_pkg::*;

  logic [7:0] cnt;
  logic [7:0] reload;

  // interval grows with the conversion-time setting
  assign reload = ({5'h00, div_sel} + 8'h01) * `SADC_STEP_BASE - 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (!enable || restart) begin
      cnt  <= reload;
      tick <= 1'b0;
    end else if (cnt == 8'h00) begin
      cnt  <= reload;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt - 8'h01;
      tick <= 1'b0;
    end
  end

endmodule : sadc_step_div

//--- hw/sadc_ctrl.sv
/*
  Converter control: APB registers, pin function routing, sample/hold and
  ten-step successive approximation sequencer, result views.
  Assumes an external comparator answering cmp_above for the code on
  sar_code, and software that keeps the documented setting order.
*/
// Decided for this implementation: the register offsets and register access over APB.
// Notes on behaviour
// - enabled comparator pin: comparator, plus convert if selected
// - comparator enable is control bit 7
// - common pin compares only when bits 4,3 set
// - unselected analog input stays unconverted, digital off
// - mode bits 5..1 give time and level
// - mode bit 0 powers the comparator
// - mode bit 7 starts selected channel conversion
// - sample fixed period, then hold until done
// - first step trials bit 9 at half
// - later bits trial one, keep if input higher
// - ten decided bits latch into result
// - done request raised with the result latch
// - conversions repeat until bit 7 cleared
// - channel write aborts, restarts while running
// - result read as 16, upper 8, lower 8
// - reset clears all result views
// - pin config bit 0 analog, resets zero
// - direction bit 1 input, resets all ones
`timescale 1ns/1ns
`include "sadc_regs.svh"

module sadc_ctrl (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  cmp_above,
  output logic      [9:0]            sar_code,
  output logic                       sample_hold,
  output logic                       comparator_power_on,
  output logic      [1:0]            op_level,
  output logic      [3:0]            channel,
  output logic                       conversion_done_irq,
  output sadc_pkg::sadc_pin_route_t  pin_route
);
  import sadc_pkg::*;

  sadc_mode_t      converter_mode_reg;
  logic [7:0]      channel_select;
  logic [7:0]      analog_pin_config_0;
  logic [7:0]      analog_pin_config_1;
  logic [7:0]      port2_direction;
  logic [7:0]      port7_direction;
  sadc_cmp_ctl_t   comparator_control [3];
  logic [15:0]     result_full;
  sadc_state_t     state;
  sadc_state_t     next_state;
  logic [3:0]      sample_cnt;
  logic [3:0]      bit_idx;
  logic [9:0]      next_sar;
  logic            tick;
  logic            wr_en;
  logic            setup;
  logic            chan_write;
  logic            conv_end;
  logic            step_restart;
  logic [31:0]     next_prdata;
  logic            next_slverr;
  sadc_pin_route_t next_route;
  logic [8:0]      pin_digital;
  logic [8:0]      pin_dir_in;
  logic            common_mode;

  // apb: no wait state, answer registered from the setup cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign chan_write = wr_en && (paddr == `SADC_OFS_CHAN_SEL);

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `SADC_OFS_CONV_MODE:    next_prdata[7:0] = converter_mode_reg;
      `SADC_OFS_CHAN_SEL:     next_prdata[7:0] = channel_select;
      `SADC_OFS_RESULT_FULL:  next_prdata[15:0] = result_full;
      `SADC_OFS_RESULT_UPPER: next_prdata[7:0] = result_full[9:2];
      `SADC_OFS_RESULT_LOWER: next_prdata[7:0] = result_full[7:0];
      `SADC_OFS_PIN_CFG0:     next_prdata[7:0] = analog_pin_config_0;
      `SADC_OFS_PIN_CFG1:     next_prdata[7:0] = analog_pin_config_1;
      `SADC_OFS_PORT2_DIR:    next_prdata[7:0] = port2_direction;
      `SADC_OFS_PORT7_DIR:    next_prdata[7:0] = port7_direction;
      `SADC_OFS_CMP_CTL0:     next_prdata[7:0] = comparator_control[0];
      `SADC_OFS_CMP_CTL1:     next_prdata[7:0] = comparator_control[1];
      `SADC_OFS_CMP_CTL2:     next_prdata[7:0] = comparator_control[2];
      `SADC_OFS_STATUS:       next_prdata[9:0] = {state, bit_idx, sample_cnt};
      default:                next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_slverr;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_mode_reg    <= `SADC_RST_MODE;
      channel_select        <= `SADC_RST_CHAN;
      analog_pin_config_0   <= `SADC_RST_PIN_CFG;
      analog_pin_config_1   <= `SADC_RST_PIN_CFG;
      port2_direction       <= `SADC_RST_PORT_DIR;
      port7_direction       <= `SADC_RST_PORT_DIR;
      comparator_control[0] <= `SADC_RST_CMP_CTL;
      comparator_control[1] <= `SADC_RST_CMP_CTL;
      comparator_control[2] <= `SADC_RST_CMP_CTL;
    end else if (wr_en) begin
      case (paddr)
        `SADC_OFS_CONV_MODE: begin
          converter_mode_reg     <= pwdata[7:0];
          converter_mode_reg.rsv <= 1'b0;
        end
        `SADC_OFS_CHAN_SEL:  channel_select <= pwdata[7:0];
        `SADC_OFS_PIN_CFG0:  analog_pin_config_0 <= pwdata[7:0];
        `SADC_OFS_PIN_CFG1:  analog_pin_config_1 <= {7'h00, pwdata[0]};
        `SADC_OFS_PORT2_DIR: port2_direction <= pwdata[7:0];
        `SADC_OFS_PORT7_DIR: port7_direction <= {7'h7F, pwdata[0]};
        `SADC_OFS_CMP_CTL0:  comparator_control[0] <= pwdata[7:0];
        `SADC_OFS_CMP_CTL1:  comparator_control[1] <= pwdata[7:0];
        `SADC_OFS_CMP_CTL2:  comparator_control[2] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    if (!converter_mode_reg.conversion_run) begin
      next_state = SADC_ST_IDLE;
    end else begin
      case (state)
        SADC_ST_IDLE:    next_state = SADC_ST_SAMPLE;
        SADC_ST_SAMPLE: begin
          if (chan_write) begin
            next_state = SADC_ST_SAMPLE;
          end else if (tick &&
                       sample_cnt == `SADC_SAMPLE_STEPS - 4'h1) begin
            next_state = SADC_ST_COMPARE;
          end
        end
        SADC_ST_COMPARE: begin
          if (chan_write) begin
            next_state = SADC_ST_SAMPLE;
          end else if (tick && bit_idx == 4'h0) begin
            next_state = SADC_ST_SAMPLE;
          end
        end
        default:         next_state = SADC_ST_IDLE;
      endcase
    end
  end

  // decide the current bit and trial the next one
  always_comb begin
    next_sar = sar_code;
    next_sar[bit_idx] = cmp_above;
    if (bit_idx != 4'h0) begin
      next_sar[bit_idx - 4'h1] = 1'b1;
    end
  end

  assign conv_end = (state == SADC_ST_COMPARE) && tick &&
                    (bit_idx == 4'h0) && !chan_write &&
                    converter_mode_reg.conversion_run;
  assign step_restart = (next_state != state) || chan_write;

  sadc_step_div u_step_div (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (state != SADC_ST_IDLE),
    .restart (step_restart),
    .div_sel (converter_mode_reg.conv_time_sel),
    .tick    (tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= SADC_ST_IDLE;
      sample_cnt  <= 4'h0;
      bit_idx     <= 4'h0;
      sar_code    <= 10'h000;
      sample_hold <= 1'b0;
    end else begin
      state       <= next_state;
      sample_hold <= (next_state == SADC_ST_SAMPLE);
      if (next_state == SADC_ST_SAMPLE && step_restart) begin
        sample_cnt <= 4'h0;
      end else if (state == SADC_ST_SAMPLE && tick) begin
        sample_cnt <= sample_cnt + 4'h1;
      end
      if (state == SADC_ST_SAMPLE && next_state == SADC_ST_COMPARE) begin
        bit_idx  <= `SADC_SAR_MSB_IDX;
        sar_code <= `SADC_SAR_TRIAL_MSB;
      end else if (state == SADC_ST_COMPARE && tick && !chan_write) begin
        sar_code <= next_sar;
        if (bit_idx != 4'h0) begin
          bit_idx <= bit_idx - 4'h1;
        end
      end
    end
  end

  // result latch and end-of-conversion request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_full         <= `SADC_RST_RESULT;
      conversion_done_irq <= 1'b0;
    end else begin
      conversion_done_irq <= conv_end;
      if (conv_end) begin
        result_full <= {6'h00, next_sar};
      end
    end
  end

  // pin function routing
  assign pin_digital = {analog_pin_config_1[0], analog_pin_config_0};
  assign pin_dir_in  = {port7_direction[0], port2_direction};
  assign common_mode = |{
    comparator_control[0].comparator_mode_sel_hi &
      comparator_control[0].comparator_mode_sel_lo,
    comparator_control[1].comparator_mode_sel_hi &
      comparator_control[1].comparator_mode_sel_lo,
    comparator_control[2].comparator_mode_sel_hi &
      comparator_control[2].comparator_mode_sel_lo};

  always_comb begin
    next_route = '0;
    for (int n = 0; n < 9; n++) begin
      next_route.digital[n] = pin_digital[n];
      next_route.convert[n] = !pin_digital[n] && pin_dir_in[n] &&
        (channel_select[`SADC_CHAN_MSB:0] == 4'(n));
    end
    next_route.comparator[3] = !pin_digital[3] && pin_dir_in[3] &&
      comparator_control[2].comparator_enable_flag;
    next_route.comparator[4] = !pin_digital[4] && pin_dir_in[4] &&
      comparator_control[0].comparator_enable_flag;
    next_route.comparator[5] = !pin_digital[5] && pin_dir_in[5] &&
      comparator_control[1].comparator_enable_flag;
    next_route.comparator[6] = !pin_digital[6] && pin_dir_in[6] &&
      common_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_route           <= '0;
      comparator_power_on <= 1'b0;
      op_level            <= 2'b00;
      channel             <= 4'h0;
    end else begin
      pin_route           <= next_route;
      comparator_power_on <= converter_mode_reg.comparator_power_on;
      op_level            <= converter_mode_reg.op_level_sel;
      channel             <= channel_select[`SADC_CHAN_MSB:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_sample;
    state == SADC_ST_SAMPLE && tick &&
      sample_cnt == 4'h3 && !chan_write && converter_mode_reg.conversion_run;
  endsequence

  sequence s_last_compare;
    state == SADC_ST_COMPARE && tick && bit_idx == 4'h0 &&
      !chan_write && converter_mode_reg.conversion_run;
  endsequence

  property p_stop;
    !converter_mode_reg.conversion_run |=> state == SADC_ST_IDLE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("converter kept running after stop");

  property p_start;
    state == SADC_ST_IDLE && converter_mode_reg.conversion_run
      |=> state == SADC_ST_SAMPLE && sample_hold ##1 sample_cnt == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not enter sampling");

  property p_hold;
    state == SADC_ST_COMPARE |-> !sample_hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("sampling during comparison");

  property p_first_bit;
    s_last_sample |=> sar_code == 10'h200 && bit_idx == 4'h9;
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first trial code wrong");

  property p_result;
    s_last_compare |=> conversion_done_irq &&
      result_full == {6'h00, $past(next_sar)};
  endproperty
  a_result: assert property (p_result)
    else $error("result not latched at end");

  property p_irq;
    conversion_done_irq |-> $past(state) == SADC_ST_COMPARE &&
      state == SADC_ST_SAMPLE ##1 !conversion_done_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("done request out of place");

  property p_abort;
    chan_write && state != SADC_ST_IDLE && converter_mode_reg.conversion_run
      |=> state == SADC_ST_SAMPLE ##1 sample_cnt == 4'h0;
  endproperty
  a_abort: assert property (p_abort)
    else $error("channel write did not restart");

  property p_power;
    ##1 comparator_power_on == $past(converter_mode_reg.comparator_power_on);
  endproperty
  a_power: assert property (p_power)
    else $error("comparator power not following mode");

  property p_common;
    ##1 pin_route.comparator[6] == $past(common_mode && pin_dir_in[6] &&
      !pin_digital[6]);
  endproperty
  a_common: assert property (p_common)
    else $error("common pin routing wrong");

endmodule : sadc_ctrl

//--- dv/sadc_analog_model.sv
/*
  Analog side model: one input level, sampled while sample_hold is high,
  held otherwise, compared with the trial code.
  Assumes the bench sets level and the design drives sar_code.
*/
`timescale 1ns/1ns

module sadc_analog_model (
  input  wire logic       pclk,
  input  wire logic       sample_hold,
  input  wire logic [9:0] sar_code,
  input  wire logic [9:0] level,
  output logic            cmp_above
);
  logic [9:0] held;

  always @(posedge pclk) begin
    if (sample_hold) begin
      held <= level;
    end
  end

  // at or above the trial level counts as above
  assign cmp_above = (held >= sar_code);
endmodule : sadc_analog_model

//--- dv/sadc_ctrl_tb_top.sv
/*
  Self-checking bench for the converter control block.
  Assumes the register header offsets and a one-cycle APB access.
*/
`timescale 1ns/1ns
`include "sadc_regs.svh"

module sadc_ctrl_tb_top;
  import sadc_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, cmp_above;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic            pready, pslverr, sample_hold, power, irq, sh_q, er;
  logic [9:0]      sar_code, level, lv;
  logic [1:0]      op_level;
  logic [3:0]      channel, ch;
  sadc_pin_route_t route, rx;
  logic [8:0]      cfg, dir;
  logic [7:0]      c0, c1, c2, v;
  logic [2:0]      ts;
  int              bad_count, samples_checked, irq_count, cyc, t0, gap, n0;
  int              pg, xr;
  int              seed = 32'h73be;
  logic [11:0]     ofs [13] = '{`SADC_OFS_CONV_MODE, `SADC_OFS_CHAN_SEL,
    `SADC_OFS_RESULT_FULL, `SADC_OFS_RESULT_UPPER, `SADC_OFS_RESULT_LOWER,
    `SADC_OFS_PIN_CFG0, `SADC_OFS_PIN_CFG1, `SADC_OFS_PORT2_DIR,
    `SADC_OFS_PORT7_DIR, `SADC_OFS_CMP_CTL0, `SADC_OFS_CMP_CTL1,
    `SADC_OFS_CMP_CTL2, `SADC_OFS_STATUS};
  logic [7:0]      rstv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  sadc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_above(cmp_above), .sar_code(sar_code), .sample_hold(sample_hold),
    .comparator_power_on(power), .op_level(op_level), .channel(channel),
    .conversion_done_irq(irq), .pin_route(route));

  sadc_analog_model i_ana (.pclk(pclk), .sample_hold(sample_hold),
    .sar_code(sar_code), .level(level), .cmp_above(cmp_above));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check_reg(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : check_reg

  task automatic check_pin(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : check_pin

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // one transfer, entered right after a rising edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check_reg(nm, e, rd);
  endtask : rd_chk

  task automatic wait_irq(int n);
    int t = 0;
    int s = irq_count;
    while (irq_count < s + n && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    check_pin("conversion done", s + n, irq_count);
  endtask : wait_irq

  task automatic wait_sh(logic s);
    int t = 0;
    while (sample_hold !== s && t < 1000) begin
      @(posedge pclk);
      t++;
    end
    check_pin("sample hold", s, sample_hold);
  endtask : wait_sh

  function automatic int sar_exp(int x);
    int c = 0;
    for (int b = 9; b >= 0; b--) if (x >= (c | (1 << b))) c |= 1 << b;
    return c;
  endfunction : sar_exp

  function automatic logic [26:0] route_exp(logic [8:0] f, d,
    logic [3:0] k, logic [7:0] a0, a1, a2);
    logic [8:0] a, cv, cp;
    a = ~f & d;
    cv = 9'h0;
    cp = 9'h0;
    if (k < 9) cv[k] = a[k];
    cp[3] = a2[7] & a[3];
    cp[4] = a0[7] & a[4];
    cp[5] = a1[7] & a[5];
    cp[6] = a[6] & ((a0[4] & a0[3]) | (a1[4] & a1[3]) | (a2[4] & a2[3]));
    return {cv, cp, f};
  endfunction : route_exp

  // done pulse count, first trial code after hold, cycle count
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sh_q <= sample_hold;
    if (irq === 1'b1) irq_count <= irq_count + 1;
    if (sh_q === 1'b1 && sample_hold === 1'b0 && n0 < 0)
      check_pin("first trial", 10'h200, sar_code);
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, level, presetn} = '0;
    {cyc, irq_count, bad_count, samples_checked} = '0;
    n0 = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      rd_chk("reset value", ofs[i], rstv[i]);
    end
    rd_chk("unmapped read", 12'h100, 32'h0);
    check_pin("unmapped error", 1'b1, er);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'h3F;
      wr(`SADC_OFS_CONV_MODE, v);
      rd_chk("mode", `SADC_OFS_CONV_MODE, v);
      check_pin("power", v[0], power);
      check_pin("level", v[2:1], op_level);
    end
    for (int i = 0; i < 6; i++) begin
      ch = 4'($random(seed));
      cfg = 9'($random(seed));
      if (ch < 9) cfg[ch] = 1'b0;
      dir = 9'($random(seed)) | ~cfg;
      c0 = 8'($random(seed)) & 8'h98;
      c1 = 8'($random(seed)) & 8'h98;
      c2 = 8'($random(seed)) & 8'h98;
      wr(`SADC_OFS_PIN_CFG0, cfg[7:0]);
      wr(`SADC_OFS_PIN_CFG1, cfg[8]);
      wr(`SADC_OFS_PORT2_DIR, dir[7:0]);
      wr(`SADC_OFS_PORT7_DIR, {7'h7F, dir[8]});
      wr(`SADC_OFS_CMP_CTL0, c0);
      wr(`SADC_OFS_CMP_CTL1, c1);
      wr(`SADC_OFS_CMP_CTL2, c2);
      wr(`SADC_OFS_CHAN_SEL, ch);
      repeat (2) @(posedge pclk);
      rx = route_exp(cfg, dir, ch, c0, c1, c2);
      check_pin("pin route", rx, route);
      check_pin("channel", ch, channel);
    end
    wr(`SADC_OFS_PIN_CFG0, 0);
    wr(`SADC_OFS_PIN_CFG1, 0);
    wr(`SADC_OFS_PORT2_DIR, 8'hFF);
    wr(`SADC_OFS_PORT7_DIR, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      ts = 3'(k * 3);
      lv = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($random(seed));
      level <= lv;
      wr(`SADC_OFS_CHAN_SEL, k + 2);
      wr(`SADC_OFS_CONV_MODE, {2'b00, ts, 3'b001});
      repeat (25) @(posedge pclk);
      n0 = -1;
      wr(`SADC_OFS_CONV_MODE, {2'b10, ts, 3'b001});
      wait_irq(1);
      t0 = cyc;
      wait_irq(1);
      gap = cyc - t0;
      // sample plus ten compare steps, one extra cycle per phase entry
      pg = (`SADC_SAMPLE_STEPS + 10) * (ts + 1) * `SADC_STEP_BASE + 2;
      check_pin("step pacing", pg, gap);
      xr = sar_exp(lv);
      rd_chk("result full", `SADC_OFS_RESULT_FULL, xr);
      rd_chk("result upper", `SADC_OFS_RESULT_UPPER, sar_exp(lv) >> 2);
      rd_chk("result lower", `SADC_OFS_RESULT_LOWER, sar_exp(lv) & 255);
      n0 = irq_count;
      wr(`SADC_OFS_CONV_MODE, {2'b00, ts, 3'b001});
      repeat (300) @(posedge pclk);
      check_pin("stopped", n0, irq_count);
      wr(`SADC_OFS_RESULT_FULL, 32'h0000_5A5A);
      rd_chk("result kept", `SADC_OFS_RESULT_FULL, sar_exp(lv));
    end
    level <= 10'h155;
    n0 = -1;
    wr(`SADC_OFS_CONV_MODE, 8'hB9);
    wait_sh(1'b1);
    wait_sh(1'b0);
    repeat (20) @(posedge pclk);
    level <= 10'h2AA;
    wr(`SADC_OFS_CHAN_SEL, 2);
    repeat (2) @(posedge pclk);
    check_pin("restart sampling", 1'b1, sample_hold);
    wait_irq(1);
    xr = sar_exp(10'h2AA);
    rd_chk("result after restart", `SADC_OFS_RESULT_FULL, xr);
    n0 = 0;
    wr(`SADC_OFS_CONV_MODE, 8'h39);
    conclude();
  end
endmodule : sadc_ctrl_tb_top
